// ==== hdl/temp_sensor_regs_oneshot.sv ====
// Register file, single-measurement control and alert logic of the temperature sensor
`timescale 1ns/1ps
`default_nettype none
module temp_sensor_regs_oneshot #(
    parameter int unsigned CONV_PERIOD_CYC = temp_sensor_pkg::CONV_PERIOD_CYCLES
) (
    // Core clock, reset, enable
    input  wire logic                      core_clk_i,
    input  wire logic                      sys_rst_i,
    input  wire logic                      core_ce_i,
    // Serial link, byte level, on the host's clock
    input  wire logic                      link_clk_i,
    input  wire temp_sensor_pkg::link_req_t link_req_i,
    output logic [7:0]                     link_rd_byte_o,
    // Converter front end
    output logic                           adc_pwr_o,
    output logic                           adc_start_o,
    input  wire logic                      adc_done_i,
    input  wire logic [11:0]               adc_code_i,
    // Alert pin level
    output logic                           overtemp_alert_out_o
);
    import temp_sensor_pkg::*;

    localparam int PW = $clog2(CONV_PERIOD_CYC + 1);

    // =========================================================
    // Link domain: reset synchroniser
    logic rst_l1;
    logic rst_l2;
    always_ff @(posedge link_clk_i) begin
        rst_l1 <= sys_rst_i;
        rst_l2 <= rst_l1;
    end

    // =========================================================
    // Link domain: registers
    logic [7:0]  register_selector;
    cfg_t        configuration;
    logic [15:0] hysteresis_limit;
    logic [15:0] overtemp_limit;
    logic [15:0] temperature_value;
    logic [7:0]  hi_hold;
    logic        byte_idx;
    logic        wr_first;
    logic        trig_tgl;
    logic        read_tgl;
    logic        set_tgl;

    // Temperature update toggle from the core, three-stage sample
    logic        temp_tgl;
    logic [15:0] temp_word;
    logic        tt_s1;
    logic        tt_s2;
    logic        tt_s3;
    logic        tt_acc;

    wire  [2:0]  sel        = register_selector[2:0];
    wire         temp_evt_l = (tt_s2 == tt_s3) && (tt_s3 != tt_acc);
    wire         ptr_wr     = link_req_i.wr_valid && wr_first;
    wire         data_wr    = link_req_i.wr_valid && !wr_first;
    wire         wide_wr    = data_wr && ((sel == SEL_HYST) || (sel == SEL_TOS));
    wire  [15:0] wide_word  = {hi_hold, link_req_i.wr_byte};

    // Read word selection; 0x04 reads back the latest result
    wire  [15:0] rd_word    = (sel == SEL_TEMP || sel == SEL_ONESHOT) ? temperature_value :
                              (sel == SEL_HYST) ? hysteresis_limit :
                              (sel == SEL_TOS)  ? overtemp_limit : 16'h0000;
    wire  [7:0]  next_rd_byte = (sel == SEL_CFG) ? configuration :
                                (byte_idx ? rd_word[7:0] : rd_word[15:8]);

    always_ff @(posedge link_clk_i) begin
        tt_s1 <= temp_tgl;
        tt_s2 <= tt_s1;
        tt_s3 <= tt_s2;
    end

    always_ff @(posedge link_clk_i) begin
        if (rst_l2) begin
            tt_acc            <= 1'b0;
            temperature_value <= TEMP_RESET;
        end else if (temp_evt_l) begin
            tt_acc            <= tt_s3;
            temperature_value <= temp_word;
        end
    end

    // Frame sequencing and selector
    always_ff @(posedge link_clk_i) begin
        if (rst_l2) begin
            register_selector <= PTR_RESET;
            wr_first          <= 1'b1;
            byte_idx          <= 1'b0;
            trig_tgl          <= 1'b0;
            read_tgl          <= 1'b0;
        end else if (link_req_i.start) begin
            wr_first <= !link_req_i.rnw;
            byte_idx <= 1'b0;
            if (link_req_i.rnw) begin
                read_tgl <= !read_tgl;
            end
        end else if (ptr_wr) begin
            register_selector <= link_req_i.wr_byte;
            wr_first          <= 1'b0;
            byte_idx          <= 1'b0;
            if (link_req_i.wr_byte[2:0] == SEL_ONESHOT) begin
                trig_tgl <= !trig_tgl;
            end
        end else if (wide_wr || link_req_i.rd_take) begin
            byte_idx <= !byte_idx;
        end
    end

    // Data writes; the temperature register and 0x04 ignore data bytes
    always_ff @(posedge link_clk_i) begin
        if (rst_l2) begin
            configuration    <= CFG_RESET;
            hysteresis_limit <= HYST_RESET;
            overtemp_limit   <= TOS_RESET;
            hi_hold          <= 8'h00;
            set_tgl          <= 1'b0;
        end else if (data_wr && !link_req_i.start) begin
            if (sel == SEL_CFG) begin
                configuration <= link_req_i.wr_byte;
                set_tgl       <= !set_tgl;
            end else if (wide_wr && !byte_idx) begin
                hi_hold <= link_req_i.wr_byte;
            end else if (wide_wr && sel == SEL_HYST) begin
                hysteresis_limit <= wide_word;
                set_tgl          <= !set_tgl;
            end else if (wide_wr) begin
                overtemp_limit <= wide_word;
                set_tgl        <= !set_tgl;
            end
        end
    end

    always_ff @(posedge link_clk_i) begin
        if (rst_l2) begin
            link_rd_byte_o <= 8'h00;
        end else begin
            link_rd_byte_o <= next_rd_byte;
        end
    end

    // =========================================================
    // Core domain: event crossings (trigger, read, settings)
    logic [2:0] ev_s1;
    logic [2:0] ev_s2;
    logic [2:0] ev_s3;
    logic [2:0] ev_acc;
    wire  [2:0] ev_in  = {set_tgl, read_tgl, trig_tgl};
    wire  [2:0] ev_hit = ~(ev_s2 ^ ev_s3) & (ev_s3 ^ ev_acc);
    wire        trig_evt = ev_hit[0];
    wire        read_evt = ev_hit[1];
    wire        set_evt  = ev_hit[2];

    always_ff @(posedge core_clk_i) begin
        if (core_ce_i) begin
            ev_s1 <= ev_in;
            ev_s2 <= ev_s1;
            ev_s3 <= ev_s2;
        end
    end

    settings_t   set_c;
    wire         powered = !set_c.cfg.shutdown && !set_c.cfg.single;

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            ev_acc <= 3'h0;
            set_c  <= {CFG_RESET, HYST_RESET, TOS_RESET};
        end else if (core_ce_i) begin
            ev_acc <= ev_s3;
            if (set_evt) begin
                set_c <= {configuration, hysteresis_limit, overtemp_limit};
            end
        end
    end

    // =========================================================
    // Core domain: conversion sequencer
    conv_state_t state;
    conv_state_t next_state;
    logic [PW-1:0] period_cnt;
    logic          single_run;

    wire  oneshot_go  = trig_evt && set_c.cfg.single;
    wire  period_done = (period_cnt == PW'(CONV_PERIOD_CYC - 1));
    wire  result_evt  = (state == ST_CONV) && adc_done_i;
    wire  conv_begin  = (next_state == ST_CONV) && (state != ST_CONV);

    always_comb begin
        next_state = state;
        unique case (state)
            ST_IDLE: begin
                if (!powered) begin
                    next_state = ST_OFF;
                end else if (period_done) begin
                    next_state = ST_CONV;
                end
            end
            ST_CONV: begin
                if (adc_done_i) begin
                    next_state = powered ? ST_IDLE : ST_OFF;
                end else if (!powered && !single_run) begin
                    next_state = ST_OFF;
                end
            end
            ST_OFF: begin
                if (powered || oneshot_go) begin
                    next_state = ST_CONV;
                end
            end
            default: next_state = ST_OFF;
        endcase
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            state       <= ST_OFF;
            period_cnt  <= '0;
            single_run  <= 1'b0;
            adc_start_o <= 1'b0;
            adc_pwr_o   <= 1'b0;
        end else if (core_ce_i) begin
            state       <= next_state;
            adc_start_o <= conv_begin;
            adc_pwr_o   <= (next_state == ST_CONV);
            if (conv_begin) begin
                period_cnt <= '0;
                single_run <= !powered;
            end else if (!period_done) begin
                period_cnt <= period_cnt + PW'(1);
            end
        end
    end

    // =========================================================
    // Core domain: result, fault queue and alert
    logic [2:0] fault_cnt;
    logic       alert_active;

    wire        over       = code_gt(adc_code_i, set_c.tos[15:4]);
    wire        below      = code_gt(set_c.hyst[15:4], adc_code_i);
    wire  [2:0] depth      = fq_depth(set_c.cfg.fault_queue);
    wire  [2:0] next_fault = !over ? 3'h0 :
                             (fault_cnt >= depth) ? depth : fault_cnt + 3'h1;
    wire        fault_hit  = over && (next_fault >= depth);
    wire        alert_set  = result_evt && fault_hit;
    wire        alert_clr  = set_c.cfg.int_mode ? read_evt :
                             (result_evt && below);
    wire        next_alert = alert_set ? 1'b1 : (alert_clr ? 1'b0 : alert_active);

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            temp_word <= TEMP_RESET;
            temp_tgl  <= 1'b0;
            fault_cnt <= 3'h0;
        end else if (core_ce_i && result_evt) begin
            temp_word <= {adc_code_i, CODE_PAD};
            temp_tgl  <= !temp_tgl;
            fault_cnt <= next_fault;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            alert_active         <= 1'b0;
            overtemp_alert_out_o <= 1'b1;
        end else if (core_ce_i) begin
            alert_active         <= next_alert;
            overtemp_alert_out_o <= set_c.cfg.polarity ? alert_active : !alert_active;
        end
    end

    // =========================================================
    // Checks
    AST_ONESHOT_STARTS: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        core_ce_i && state == ST_OFF && set_c.cfg.single && trig_evt
        |=> adc_start_o && state == ST_CONV)
        else $error("single-measurement trigger did not start a conversion");

    AST_SINGLE_SHUTS_DOWN: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        core_ce_i && state == ST_IDLE && set_c.cfg.single
        |=> state == ST_OFF && !adc_start_o ##1 !adc_pwr_o)
        else $error("single-measurement mode did not power down");

    AST_SHUTDOWN_QUIET: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        state == ST_OFF && set_c.cfg.shutdown && !set_c.cfg.single
        |=> !adc_start_o && !adc_pwr_o)
        else $error("conversion started while shut down");

    AST_RESULT_FORMAT: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        core_ce_i && result_evt
        |=> temp_word == {$past(adc_code_i), 4'h0} && temp_tgl != $past(temp_tgl))
        else $error("result word not formatted as 12-bit code");

    AST_ALERT_CAUSE: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        $rose(alert_active) |-> $past(result_evt && fault_hit && core_ce_i))
        else $error("alert rose without a queued overtemperature result");

    AST_INT_READ_CLEARS: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        core_ce_i && set_c.cfg.int_mode && read_evt && !alert_set
        |=> !alert_active ##1 overtemp_alert_out_o == !set_c.cfg.polarity)
        else $error("register read did not clear alert in interrupt mode");

    AST_CMP_BELOW_CLEARS: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        core_ce_i && !set_c.cfg.int_mode && result_evt && below && !fault_hit
        |=> !alert_active)
        else $error("result below hysteresis did not clear comparator alert");

    AST_QUEUE_RESETS: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        core_ce_i && result_evt && !over |=> fault_cnt == 3'h0)
        else $error("fault queue not cleared by a normal result");

    AST_POLARITY: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        core_ce_i
        |=> overtemp_alert_out_o == ($past(set_c.cfg.polarity) ~^ $past(alert_active)))
        else $error("alert pin level disagrees with polarity");

    AST_TRIGGER_TOGGLE: assert property (@(posedge link_clk_i) disable iff (rst_l2)
        ptr_wr && !link_req_i.start && link_req_i.wr_byte[2:0] == SEL_ONESHOT
        |=> trig_tgl != $past(trig_tgl) && sel == SEL_ONESHOT)
        else $error("selector write of 0x04 did not trigger");

    AST_TEMP_READONLY: assert property (@(posedge link_clk_i) disable iff (rst_l2)
        data_wr && sel == SEL_TEMP && !temp_evt_l |=> $stable(temperature_value))
        else $error("temperature register changed on a host write");

    AST_MSB_FIRST: assert property (@(posedge link_clk_i) disable iff (rst_l2)
        (link_req_i.start && link_req_i.rnw && sel == SEL_HYST) ##1 !link_req_i.rd_take
        |=> link_rd_byte_o == hysteresis_limit[15:8])
        else $error("16-bit read did not begin with the high byte");

    AST_LOW_BYTE_NEXT: assert property (@(posedge link_clk_i) disable iff (rst_l2)
        link_req_i.rd_take && !link_req_i.start && !link_req_i.wr_valid && !byte_idx
        && sel != SEL_CFG |=> ##1 link_rd_byte_o == $past(rd_word[7:0]))
        else $error("16-bit read did not continue with the low byte");

    AST_CFG_READBACK: assert property (@(posedge link_clk_i) disable iff (rst_l2)
        link_req_i.start && link_req_i.rnw && sel == SEL_CFG
        |=> ##1 link_rd_byte_o == $past(configuration))
        else $error("configuration read did not return the stored byte");

    AST_SELECTOR_LOADS: assert property (@(posedge link_clk_i) disable iff (rst_l2)
        ptr_wr && !link_req_i.start |=> register_selector == $past(link_req_i.wr_byte))
        else $error("selector byte not stored");

    AST_RESET_OUTPUTS: assert property (@(posedge core_clk_i)
        sys_rst_i |=> overtemp_alert_out_o && !adc_pwr_o && !adc_start_o)
        else $error("outputs not at their idle levels after reset");

    AST_SET_WINS: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        core_ce_i && alert_set |=> alert_active)
        else $error("queued overtemperature result did not raise the alert");

    AST_SINGLE_POWERS_OFF: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        core_ce_i && result_evt && single_run && !powered |=> state == ST_OFF && !adc_pwr_o)
        else $error("single measurement did not power down after its result");

    AST_QUEUE_COUNTS: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        core_ce_i && result_evt && over && fault_cnt < depth
        |=> fault_cnt == $past(fault_cnt) + 3'h1)
        else $error("fault queue did not count a consecutive overtemperature result");

    AST_SHUTDOWN_STOPS: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        core_ce_i && state == ST_IDLE && set_c.cfg.shutdown |=> state == ST_OFF && !adc_start_o)
        else $error("shutdown did not stop automatic conversions");

    AST_CONV_PAIRS_PWR: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        adc_start_o |-> adc_pwr_o)
        else $error("conversion started with the converter unpowered");

endmodule
`default_nettype wire

// ==== hdl/temp_sensor_pkg.sv ====
// Constants, carrier types and helpers of the temperature sensor register block
// Notes on behaviour
// - Temperature is a 12-bit two's complement code, 1/16 degree per step.
// - Config bit 5 enables single-measurement mode and shuts down automatic conversions at once.
// - In single-measurement mode, selector write of 0x04 runs exactly one conversion.
// - Reading selector 0x04 returns the latest result, same as the temperature register.
// - A trigger write raises the alert if its result over the overtemperature limit fills the fault queue, both modes.
// - Interrupt mode: any register read clears the alert after a trigger raised it.
// - Comparator mode: once below hysteresis, the next trigger clears the alert.
// - Config bits 4:3 set a fault queue up to six consecutive overtemperature results.
// - Configuration is 8 bits wide; temperature and both limits are 16 bits.
// - Temperature register and 0x04 are read-only; the rest take reads and writes.
// - The selector clears to 0x00 at power-up, pointing at the temperature register.
// - Power-up values: hysteresis 0x4b00, overtemperature 0x5000, config and temperature zero.
// - The 8-bit write-only selector picks the data register for following data bytes.
// - Selector codes 0 to 4: temperature, config, hysteresis, overtemperature, single measurement.
// - A 16-bit register is read high byte first, then low byte.
// - Config layout: bus alert, reserved, single, queue, polarity, mode, shutdown; reset zero.
// - Config bit 0 at one powers everything but the serial side down; zero wakes.
// - Config bit 1 at zero selects comparator alert behaviour, at one interrupt.
// - Config bit 2 at zero makes the alert active low, at one active high.
// - Queue field 00 needs a single overtemperature fault before the alert asserts.
package temp_sensor_pkg;

    // =========================================================
    // Register selection and reset values
    localparam logic [2:0]  SEL_TEMP    = 3'h0;
    localparam logic [2:0]  SEL_CFG     = 3'h1;
    localparam logic [2:0]  SEL_HYST    = 3'h2;
    localparam logic [2:0]  SEL_TOS     = 3'h3;
    localparam logic [2:0]  SEL_ONESHOT = 3'h4;
    localparam logic [7:0]  PTR_RESET   = 8'h00;
    localparam logic [7:0]  CFG_RESET   = 8'h00;
    localparam logic [15:0] TEMP_RESET  = 16'h0000;
    localparam logic [15:0] HYST_RESET  = 16'h4b00;
    localparam logic [15:0] TOS_RESET   = 16'h5000;
    localparam logic [3:0]  CODE_PAD    = 4'h0;

    // =========================================================
    // Fault queue depths per field value
    localparam logic [2:0]  FQ_DEPTH_0  = 3'h1;
    localparam logic [2:0]  FQ_DEPTH_1  = 3'h2;
    localparam logic [2:0]  FQ_DEPTH_2  = 3'h4;
    localparam logic [2:0]  FQ_DEPTH_3  = 3'h6;

    // =========================================================
    // Timing
    localparam int          CORE_CLK_KHZ       = 200000;
    localparam int          CONV_PERIOD_MS     = 100;
    localparam int          CONV_PERIOD_CYCLES = CONV_PERIOD_MS * CORE_CLK_KHZ;

    // =========================================================
    // Carrier types
    typedef struct packed {
        logic       bus_alert;
        logic       reserved;
        logic       single;
        logic [1:0] fault_queue;
        logic       polarity;
        logic       int_mode;
        logic       shutdown;
    } cfg_t;

    typedef struct packed {
        cfg_t        cfg;
        logic [15:0] hyst;
        logic [15:0] tos;
    } settings_t;

    typedef struct packed {
        logic       start;
        logic       rnw;
        logic       wr_valid;
        logic [7:0] wr_byte;
        logic       rd_take;
    } link_req_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_CONV = 2'b01,
        ST_OFF  = 2'b11
    } conv_state_t;

    // =========================================================
    // Helpers
    function automatic logic code_gt(input logic [11:0] a, input logic [11:0] b);
        return $signed(a) > $signed(b);
    endfunction

    function automatic logic [2:0] fq_depth(input logic [1:0] field);
        logic [2:0] d;
        d = FQ_DEPTH_0;
        unique case (field)
            2'b00: d = FQ_DEPTH_0;
            2'b01: d = FQ_DEPTH_1;
            2'b10: d = FQ_DEPTH_2;
            2'b11: d = FQ_DEPTH_3;
        endcase
        return d;
    endfunction

endpackage

// ==== tb/temp_sensor_host_model.sv ====
// Host side model: byte-level register frames on its own gated link clock
`timescale 1ns/1ps
`default_nettype none
module temp_sensor_host_model (
    // Link towards the device
    output logic                       link_clk_o,
    output temp_sensor_pkg::link_req_t link_req_o,
    input  wire logic [7:0]            link_rd_byte_i
);
    import temp_sensor_pkg::*;
    initial begin
        link_clk_o = 1'b0;
    end
    // =========================================================
    // Link cycles
    // Request held over the rising edge; stale data byte is inverted just after it
    task automatic cyc(input link_req_t r);
        link_req_o = r;
        #62.5 link_clk_o = 1'b1;
        #1 link_req_o = '{wr_byte: ~r.wr_byte, default: 1'b0};
        #61.5 link_clk_o = 1'b0;
    endtask
    task automatic idle(input int n);
        repeat (n) cyc('0);
    endtask
    task automatic start(input logic rnw);
        cyc('{start: 1'b1, rnw: rnw, default: '0});
    endtask
    task automatic put(input logic [7:0] b);
        cyc('{wr_valid: 1'b1, wr_byte: b, default: '0});
    endtask
    // =========================================================
    // Frames
    task automatic wr(input logic [2:0] sel, input int n, input logic [15:0] d);
        start(1'b0);
        put({5'h00, sel});
        if (n == 2) put(d[15:8]);
        if (n > 0) put(d[7:0]);
        idle(2);
    endtask
    // Read on the stored selector; spare edges carry fresh data across
    task automatic rd(input int n, output logic [15:0] d);
        start(1'b1);
        idle(4);
        d = {link_rd_byte_i, 8'h00};
        if (n == 2) begin
            cyc('{rd_take: 1'b1, default: '0});
            idle(1);
            d[7:0] = link_rd_byte_i;
        end
    endtask
endmodule
`default_nettype wire

// ==== tb/temp_sensor_regs_oneshot_tb_top.sv ====
// Self-checking bench of the register block with converter stand-in and host model
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_errors++; \
    $display("Error at %0t: got %h expected %h", $time, (g), (e)); end end
module temp_sensor_regs_oneshot_tb_top;
    import temp_sensor_pkg::*;
    logic        core_clk_i = 1'b0;
    logic        sys_rst_i  = 1'b1;
    logic        adc_done_i = 1'b0;
    logic [11:0] adc_code_i = 12'h000;
    logic [11:0] code       = 12'h000;
    logic        core_ce    = 1'b1;
    logic        link_clk, adc_pwr, adc_start, alert;
    logic [7:0]  rd_byte;
    logic [15:0] v, d;
    link_req_t   req;
    int seed = 82, n_errors = 0, n_compared = 0, n_starts = 0, ncyc = 0, cnt = 0, s0;
    int          n_pwr = 0, p0;
    int          dep[4] = '{1, 2, 4, 6};
    logic [15:0] rv[4] = '{16'h0000, 16'h0000, 16'h4b00, 16'h5000};

    temp_sensor_regs_oneshot #(.CONV_PERIOD_CYC(200)) dut (
        .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .core_ce_i(core_ce),
        .link_clk_i(link_clk), .link_req_i(req), .link_rd_byte_o(rd_byte),
        .adc_pwr_o(adc_pwr), .adc_start_o(adc_start), .adc_done_i(adc_done_i),
        .adc_code_i(adc_code_i), .overtemp_alert_out_o(alert));
    temp_sensor_host_model host (
        .link_clk_o(link_clk), .link_req_o(req), .link_rd_byte_i(rd_byte));

    // =========================================================
    // Clock, converter stand-in, timeout
    always #2.5 core_clk_i = ~core_clk_i;
    always @(negedge core_clk_i) begin
        adc_done_i <= (cnt == 1);
        adc_code_i <= (cnt == 1) ? code : ~code;
        if (adc_start === 1'b1) cnt <= 3 + ($random(seed) & 7);
        else if (cnt > 0) cnt <= cnt - 1;
    end
    always @(posedge core_clk_i) begin
        n_starts <= n_starts + int'(adc_start === 1'b1);
        n_pwr <= n_pwr + int'(adc_pwr === 1'b1);
        ncyc <= ncyc + 1;
        if (ncyc == 30000) begin
            n_errors++;
            conclude();
        end
    end

    // =========================================================
    // Helpers
    task automatic conclude;
        $display("Counts: %0d compared, %0d mismatches", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic rdreg(input logic [2:0] s);
        host.start(1'b0);
        host.put({5'h00, s});
        host.rd((s == 3'h1) ? 1 : 2, v);
    endtask
    task automatic trig(input logic [11:0] c);
        s0 = n_starts;
        p0 = n_pwr;
        code = c;
        host.start(1'b0);
        host.put(8'h04);
        host.idle(2);
        `CHK(n_starts - s0, 1)
        `CHK(n_pwr != p0, 1'b1)
        `CHK(adc_pwr, 1'b0)
    endtask
    function automatic logic [11:0] over();
        return 12'h501 + 12'($random(seed) & 255);
    endfunction

    // =========================================================
    // Scenarios
    initial begin
        host.idle(6);
        @(negedge core_clk_i) sys_rst_i = 1'b0;
        host.idle(3);
        `CHK(alert, 1'b1)
        host.rd(2, v);
        `CHK(v, 16'h0000)
        for (int s = 1; s < 4; s++) begin
            rdreg(3'(s));
            `CHK(v, rv[s])
        end
        $display("done: reset values");
        code = {1'b1, 11'($random(seed))};
        host.idle(20);
        rdreg(3'h0);
        `CHK(v, {code, 4'h0})
        `CHK(v[15:8], code[11:4])
        for (int s = 0; s < 4; s++) begin
            d = 16'($random(seed));
            host.wr(3'(s), (s == 1) ? 1 : 2, d);
            rdreg(3'(s));
            `CHK(v, (s == 0) ? {code, 4'h0} : (s == 1) ? {d[7:0], 8'h00} : d)
        end
        host.wr(3'h2, 2, 16'h4b00);
        host.wr(3'h3, 2, 16'h5000);
        $display("done: register access");
        host.wr(3'h1, 1, 16'h0001);
        s0 = n_starts;
        host.idle(20);
        `CHK(n_starts - s0, 0)
        `CHK(adc_pwr, 1'b0)
        host.wr(3'h1, 1, 16'h0000);
        `CHK(n_starts - s0, 1)
        @(negedge core_clk_i) core_ce = 1'b0;
        s0 = n_starts;
        host.idle(20);
        `CHK(n_starts - s0, 0)
        @(negedge core_clk_i) core_ce = 1'b1;
        s0 = n_starts;
        host.idle(8);
        `CHK(n_starts - s0, 1)
        host.wr(3'h1, 1, 16'h0020);
        s0 = n_starts;
        host.idle(20);
        `CHK(n_starts - s0, 0)
        $display("done: power modes");
        trig(over());
        `CHK(alert, 1'b0)
        host.rd(2, v);
        `CHK(v, {code, 4'h0})
        rdreg(3'h0);
        `CHK(v, {code, 4'h0})
        trig(12'h400);
        `CHK(alert, 1'b1)
        host.wr(3'h1, 1, 16'h0026);
        `CHK(alert, 1'b0)
        trig(over());
        `CHK(alert, 1'b1)
        host.rd(1, v);
        `CHK(alert, 1'b0)
        $display("done: single measurement alert");
        for (int q = 0; q < 4; q++) begin
            host.wr(3'h1, 1, {8'h00, 3'b001, 2'(q), 3'b000});
            trig(12'h100);
            repeat (dep[q] - 1) trig(over());
            `CHK(alert, 1'b1)
            trig(over());
            `CHK(alert, 1'b0)
        end
        $display("done: fault queue");
        conclude();
    end
endmodule
`default_nettype wire
